// file: src/cdc_power_control_regs.sv
// Purpose: Register banks and power/conversion control of a touch converter
// Assumes: Byte traffic arrives already deserialised, on SYS_CLK_IN
// Notes: Sequence timer drives conversion starts from the control word
//
// What this block does
// - Address space split into control, configuration and result banks.
// - Result bank refreshed automatically as each conversion sequence runs.
// - Result bank stays readable by the host.
// - Configuration and result banks hold undefined data until programmed.
// - Mode 00 full power every 36 ms, 10 low power, 01/11 shutdown.
// - Low power wake delay 200, 400, 600 or 800 ms by code.
// - Stages per sequence equal field plus one, at most twelve.
// - Decimation 256, 128, or 64 for codes 10 and 11.
// - Writing bit 10 restores defaults; the bit clears itself.
// - Bit 12 zero enables excitation drive, one disables it.
// - Bias boost 0, 20, 35 or 50 percent by code.
// - Sixteen-bit registers move as two bytes, upper first; unpaired writes dropped.

`timescale 1ns/100ps
`default_nettype none

module cdc_power_control_regs
	import cdc_regs_pkg::*;
#(
	parameter int unsigned FP_PERIOD_CYC = FP_INTERVAL_CYC,
	parameter int unsigned LP_UNIT_CYC = LP_STEP_CYC
) (
	// Clock, reset, enable
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	// Host byte port
	input wire logic [9:0] ADDR_IN,
	input wire logic WR_BYTE_VALID_IN,
	input wire logic [7:0] WR_BYTE_IN,
	input wire logic RD_BYTE_REQ_IN,
	input wire logic FRAME_END_IN,
	output logic RD_BYTE_VALID_OUT,
	output logic [7:0] RD_BYTE_OUT,
	// Converter results
	input wire logic RESULT_VALID_IN,
	input wire logic [3:0] RESULT_STAGE_IN,
	input wire logic [15:0] RESULT_DATA_IN,
	// Converter control
	output logic CONV_START_OUT,
	output logic SEQ_DONE_OUT,
	output logic SHUTDOWN_OUT,
	output logic LOW_POWER_OUT,
	output logic [3:0] STAGE_COUNT_OUT,
	output logic [8:0] DECIMATION_OUT,
	output logic EXCITE_EN_OUT,
	output logic [1:0] BIAS_BOOST_OUT,
	output logic IRQ_ACTIVE_HIGH_OUT
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic bank_e bank_of(input logic [9:0] a);
		if (a < CFG_BANK_BASE) begin
			return BANK_CTRL;
		end else if (a < RES_BANK_BASE) begin
			return BANK_CFG;
		end else if (a < RES_BANK_END) begin
			return BANK_RES;
		end else begin
			return BANK_NONE;
		end
	endfunction

	function automatic logic [8:0] decim_of(input logic [1:0] code);
		case (code)
			2'b00: return DECIM_256;
			2'b01: return DECIM_128;
			default: return DECIM_64;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0] pwr_ctrl;
	logic [7:0] wr_hi;
	logic [9:0] wr_addr;
	logic wr_pending;
	logic word_we;
	logic [15:0] word_data;
	logic rd_phase;
	logic rd_wait;
	logic [15:0] rd_shadow;
	bank_e rd_bank;
	logic [15:0] cfg_q;
	logic [15:0] res_q;
	logic [15:0] rd_word;
	logic [31:0] seq_cnt;
	logic [31:0] seq_period;
	logic shutdown;
	logic [3:0] stage_count;
	logic soft_restore_defaults;

	assign word_data = {wr_hi, WR_BYTE_IN};
	assign word_we = CE_IN && WR_BYTE_VALID_IN && wr_pending;
	assign shutdown = pwr_ctrl[MODE_LO] == 1'b1;
	assign soft_restore_defaults = word_we && (bank_of(wr_addr) == BANK_CTRL)
		&& (wr_addr == PWR_CTRL_ADDR) && word_data[SOFT_RST_BIT];

	// ----------------------------------------------------------------
	// Write byte pairing
	// ----------------------------------------------------------------
	// Upper byte first; a frame that ends on a lone byte loses it
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			wr_pending <= 1'b0;
			wr_hi <= '0;
			wr_addr <= '0;
		end else if (CE_IN) begin
			if (FRAME_END_IN) begin
				wr_pending <= 1'b0;
			end else if (WR_BYTE_VALID_IN) begin
				if (!wr_pending) begin
					wr_hi <= WR_BYTE_IN;
					wr_addr <= ADDR_IN;
				end
				wr_pending <= !wr_pending;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control word
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			pwr_ctrl <= PWR_CTRL_RESET;
		end else if (CE_IN) begin
			if (soft_restore_defaults) begin
				pwr_ctrl <= PWR_CTRL_RESET;
			end else if (word_we && wr_addr == PWR_CTRL_ADDR) begin
				// Reset bit and unused bit never stored
				pwr_ctrl <= word_data & PWR_CTRL_WMASK;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration and result banks
	// ----------------------------------------------------------------
	logic cfg_we;
	logic [CFG_AW-1:0] cfg_waddr;
	logic [CFG_AW-1:0] cfg_raddr;
	logic res_we;
	logic [RES_AW-1:0] res_raddr;

	assign cfg_we = word_we && (bank_of(wr_addr) == BANK_CFG);
	assign cfg_waddr = CFG_AW'(wr_addr - CFG_BANK_BASE);
	assign cfg_raddr = CFG_AW'(ADDR_IN - CFG_BANK_BASE);
	assign res_raddr = RES_AW'(ADDR_IN - RES_BANK_BASE);
	// Converter owns the result bank; host writes there are ignored
	assign res_we = RESULT_VALID_IN && (RESULT_STAGE_IN < stage_count);

	// Memories carry no reset: contents stay undefined until written
	cdc_word_mem #(.WIDTH(REG_W), .DEPTH(CFG_DEPTH), .AW(CFG_AW)) u_cfg_mem (
		.clk_in(SYS_CLK_IN),
		.ce_in(CE_IN),
		.we_in(cfg_we),
		.waddr_in(cfg_waddr),
		.wdata_in(word_data),
		.raddr_in(cfg_raddr),
		.rdata_out(cfg_q)
	);

	cdc_word_mem #(.WIDTH(REG_W), .DEPTH(RES_DEPTH), .AW(RES_AW)) u_res_mem (
		.clk_in(SYS_CLK_IN),
		.ce_in(CE_IN),
		.we_in(res_we),
		.waddr_in(RESULT_STAGE_IN),
		.wdata_in(RESULT_DATA_IN),
		.raddr_in(res_raddr),
		.rdata_out(res_q)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		case (rd_bank)
			BANK_CTRL: rd_word = (rd_shadow[0] == 1'b0) ? pwr_ctrl : '0;
			BANK_CFG: rd_word = cfg_q;
			BANK_RES: rd_word = res_q;
			default: rd_word = '0;
		endcase
	end

	// Upper byte two cycles after its request, lower byte one cycle after
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			rd_phase <= 1'b0;
			rd_wait <= 1'b0;
			rd_bank <= BANK_NONE;
			rd_shadow <= '0;
			RD_BYTE_VALID_OUT <= 1'b0;
			RD_BYTE_OUT <= '0;
		end else if (CE_IN) begin
			RD_BYTE_VALID_OUT <= 1'b0;
			rd_wait <= 1'b0;
			if (RD_BYTE_REQ_IN && !rd_phase && !rd_wait) begin
				rd_bank <= bank_of(ADDR_IN);
				// Only the control word exists in the control bank
				rd_shadow <= {15'h0000, ADDR_IN != PWR_CTRL_ADDR};
				rd_wait <= 1'b1;
			end else if (rd_wait) begin
				rd_shadow <= rd_word;
				RD_BYTE_OUT <= rd_word[15:8];
				RD_BYTE_VALID_OUT <= 1'b1;
				rd_phase <= 1'b1;
			end else if (RD_BYTE_REQ_IN && rd_phase) begin
				RD_BYTE_OUT <= rd_shadow[7:0];
				RD_BYTE_VALID_OUT <= 1'b1;
				rd_phase <= 1'b0;
			end
			if (FRAME_END_IN) begin
				rd_phase <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequence timer
	// ----------------------------------------------------------------
	// Low power period scales with the wake code; full power period is fixed
	always_comb begin
		if (pwr_ctrl[MODE_LO+1 -: 2] == MODE_LOW) begin
			seq_period = 32'((32'(pwr_ctrl[WAKE_LO+1 -: 2]) + 32'd1) * LP_UNIT_CYC);
		end else begin
			seq_period = FP_PERIOD_CYC;
		end
	end

	// Codes above the maximum clamp rather than wrap
	always_comb begin
		if (pwr_ctrl[STAGES_LO+3 -: 4] >= STAGES_MAX_CODE) begin
			stage_count = STAGES_MAX;
		end else begin
			stage_count = pwr_ctrl[STAGES_LO+3 -: 4] + 4'h1;
		end
	end

	// Restarting on a mode write would need compare logic; period just reloads
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			seq_cnt <= '0;
			CONV_START_OUT <= 1'b0;
		end else if (CE_IN) begin
			CONV_START_OUT <= 1'b0;
			if (shutdown || soft_restore_defaults) begin
				seq_cnt <= '0;
			end else if (seq_cnt >= seq_period - 32'd1) begin
				seq_cnt <= '0;
				CONV_START_OUT <= 1'b1;
			end else begin
				seq_cnt <= seq_cnt + 32'd1;
			end
		end
	end

	// Done marks the last enabled stage landing, not a timer event
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			SEQ_DONE_OUT <= 1'b0;
		end else if (CE_IN) begin
			SEQ_DONE_OUT <= res_we && (RESULT_STAGE_IN == stage_count - 4'h1);
		end
	end

	// ----------------------------------------------------------------
	// Converter setting outputs
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			SHUTDOWN_OUT <= 1'b0;
			LOW_POWER_OUT <= 1'b0;
			STAGE_COUNT_OUT <= 4'h1;
			DECIMATION_OUT <= DECIM_256;
			EXCITE_EN_OUT <= 1'b1;
			BIAS_BOOST_OUT <= 2'b00;
			IRQ_ACTIVE_HIGH_OUT <= 1'b0;
		end else if (CE_IN) begin
			SHUTDOWN_OUT <= shutdown;
			LOW_POWER_OUT <= pwr_ctrl[MODE_LO+1 -: 2] == MODE_LOW;
			STAGE_COUNT_OUT <= stage_count;
			DECIMATION_OUT <= decim_of(pwr_ctrl[DECIM_LO+1 -: 2]);
			EXCITE_EN_OUT <= !pwr_ctrl[EXC_GATE_BIT];
			BIAS_BOOST_OUT <= pwr_ctrl[BOOST_LO+1 -: 2];
			IRQ_ACTIVE_HIGH_OUT <= pwr_ctrl[IRQ_POL_BIT];
		end
	end

endmodule // cdc_power_control_regs

`default_nettype wire

// file: src/cdc_regs_pkg.sv
// Purpose: Shared constants for the converter control register block
// Assumes: 200 MHz system clock, 16-bit registers, 10-bit word addresses
// Notes: Bank boundaries and timing figures live here only

package cdc_regs_pkg;

	// ----------------------------------------------------------------
	// Register geometry
	// ----------------------------------------------------------------
	localparam int unsigned REG_W = 16;
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned BYTE_W = 8;

	// ----------------------------------------------------------------
	// Bank map (word addresses)
	// ----------------------------------------------------------------
	localparam logic [9:0] CTRL_BANK_BASE = 10'h000;
	localparam logic [9:0] CFG_BANK_BASE = 10'h080;
	localparam logic [9:0] RES_BANK_BASE = 10'h0e0;
	localparam logic [9:0] RES_BANK_END = 10'h0ec;
	localparam logic [9:0] PWR_CTRL_ADDR = 10'h000;
	localparam int unsigned CFG_DEPTH = 96;
	localparam int unsigned RES_DEPTH = 12;
	localparam int unsigned CFG_AW = 7;
	localparam int unsigned RES_AW = 4;

	typedef enum logic [1:0] {
		BANK_CTRL = 2'b00,
		BANK_CFG = 2'b01,
		BANK_RES = 2'b10,
		BANK_NONE = 2'b11
	} bank_e;

	// ----------------------------------------------------------------
	// Control word fields
	// ----------------------------------------------------------------
	localparam int unsigned MODE_LO = 0;
	localparam int unsigned WAKE_LO = 2;
	localparam int unsigned STAGES_LO = 4;
	localparam int unsigned DECIM_LO = 8;
	localparam int unsigned SOFT_RST_BIT = 10;
	localparam int unsigned IRQ_POL_BIT = 11;
	localparam int unsigned EXC_GATE_BIT = 12;
	localparam int unsigned UNUSED_BIT = 13;
	localparam int unsigned BOOST_LO = 14;
	localparam logic [15:0] PWR_CTRL_RESET = 16'h0000;
	localparam logic [15:0] PWR_CTRL_WMASK = 16'hdbff;

	localparam logic [1:0] MODE_FULL = 2'b00;
	localparam logic [1:0] MODE_LOW = 2'b10;
	localparam logic [3:0] STAGES_MAX_CODE = 4'hb;
	localparam logic [3:0] STAGES_MAX = 4'hc;

	localparam logic [8:0] DECIM_256 = 9'h100;
	localparam logic [8:0] DECIM_128 = 9'h080;
	localparam logic [8:0] DECIM_64 = 9'h040;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ = 200000000;
	localparam int unsigned FP_INTERVAL_MS = 36;
	localparam int unsigned LP_STEP_MS = 200;
	localparam int unsigned FP_INTERVAL_CYC = (SYS_CLK_HZ / 1000) * FP_INTERVAL_MS;
	localparam int unsigned LP_STEP_CYC = (SYS_CLK_HZ / 1000) * LP_STEP_MS;

endpackage

// file: src/cdc_word_mem.sv
// Purpose: Small word memory with one write port and a registered read
// Assumes: Contents are undefined until written
// Notes: No reset on the array on purpose

`timescale 1ns/100ps
`default_nettype none

module cdc_word_mem #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 12,
	parameter int unsigned AW = 4
) (
	// Clock
	input wire logic clk_in,
	input wire logic ce_in,
	// Write port
	input wire logic we_in,
	input wire logic [AW-1:0] waddr_in,
	input wire logic [WIDTH-1:0] wdata_in,
	// Read port
	input wire logic [AW-1:0] raddr_in,
	output logic [WIDTH-1:0] rdata_out
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_in) begin
		if (ce_in && we_in && (32'(waddr_in) < DEPTH)) begin
			mem[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (ce_in) begin
			rdata_out <= (32'(raddr_in) < DEPTH) ? mem[raddr_in] : '0;
		end
	end

endmodule // cdc_word_mem

`default_nettype wire

// file: tb/cdc_host_model.sv
// Purpose: Host side of the byte register port
// Assumes: Requests launched 1 ns after the rising edge
// Notes: Released lines show inverted values
`timescale 1ns/100ps
`default_nettype none
module cdc_host_model (
	// Clock and answers
	input wire logic clk_in,
	input wire logic rd_valid_in,
	input wire logic [7:0] rd_byte_in,
	// Requests
	output logic [9:0] addr_out,
	output logic wr_valid_out,
	output logic [7:0] wr_byte_out,
	output logic rd_req_out,
	output logic frame_end_out
);
	initial begin
		addr_out = 10'h0;
		wr_valid_out = 1'b0;
		wr_byte_out = 8'h0;
		rd_req_out = 1'b0;
		frame_end_out = 1'b0;
	end
	task automatic step;
		@(posedge clk_in);
		#1;
	endtask
	// Upper byte first; a lone upper byte is closed by frame end
	task automatic wr(input logic [9:0] a, input logic [15:0] d, input bit pair = 1'b1);
		step();
		addr_out = a;
		wr_valid_out = 1'b1;
		wr_byte_out = d[15:8];
		if (pair) begin
			step();
			wr_byte_out = d[7:0];
		end
		step();
		wr_valid_out = 1'b0;
		addr_out = ~a;
		wr_byte_out = ~wr_byte_out;
		frame_end_out = !pair;
		step();
		frame_end_out = 1'b0;
	endtask
	// Waiting out each byte keeps requests off the busy cycle
	task automatic get(output logic [7:0] b);
		rd_req_out = 1'b1;
		step();
		rd_req_out = 1'b0;
		for (int k = 0; k < 4 && rd_valid_in !== 1'b1; k++) step();
		b = (rd_valid_in === 1'b1) ? rd_byte_in : 8'hxx;
		step();
	endtask
	task automatic rd(input logic [9:0] a, output logic [15:0] d);
		step();
		addr_out = a;
		get(d[15:8]);
		get(d[7:0]);
		addr_out = ~a;
	endtask
endmodule // cdc_host_model
`default_nettype wire

// file: tb/cdc_regs_checker.sv
// Purpose: Port assertions of the control register block
// Assumes: Bound to the top module, one clock
// Notes: Sees ports only
`timescale 1ns/100ps
`default_nettype none
module cdc_regs_checker (
	// Clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	// Watched
	input wire logic RESULT_VALID_IN,
	input wire logic CONV_START_OUT,
	input wire logic SEQ_DONE_OUT,
	input wire logic SHUTDOWN_OUT,
	input wire logic LOW_POWER_OUT,
	input wire logic [3:0] STAGE_COUNT_OUT,
	input wire logic [8:0] DECIMATION_OUT,
	input wire logic EXCITE_EN_OUT,
	input wire logic [1:0] BIAS_BOOST_OUT
);
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	mode_excl_a: assert property (!(SHUTDOWN_OUT && LOW_POWER_OUT))
		else $error("two modes at once");
	// Two cycles of slack: a wrap launched before the mode change may still land
	idle_quiet_a: assert property (SHUTDOWN_OUT && $past(SHUTDOWN_OUT, 2) |-> !CONV_START_OUT)
		else $error("start in shutdown");
	start_pulse_a: assert property (CONV_START_OUT |=> !CONV_START_OUT)
		else $error("start too long");
	start_gap_a: assert property (CONV_START_OUT && !SHUTDOWN_OUT |=> !CONV_START_OUT [*8])
		else $error("starts too close");
	decim_code_a: assert property (DECIMATION_OUT inside {9'h100, 9'h080, 9'h040})
		else $error("bad decimation");
	stage_range_a: assert property (STAGE_COUNT_OUT inside {[4'h1:4'hc]})
		else $error("bad stage count");
	reset_dflt_a: assert property ($rose(RST_N_IN) |-> EXCITE_EN_OUT && BIAS_BOOST_OUT == 2'h0)
		else $error("not default after reset");
	done_src_a: assert property (SEQ_DONE_OUT |-> $past(RESULT_VALID_IN) || $past(RESULT_VALID_IN, 2))
		else $error("done without result");
endmodule // cdc_regs_checker
bind cdc_power_control_regs cdc_regs_checker u_chk (
	.SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .RESULT_VALID_IN(RESULT_VALID_IN),
	.CONV_START_OUT(CONV_START_OUT), .SEQ_DONE_OUT(SEQ_DONE_OUT), .SHUTDOWN_OUT(SHUTDOWN_OUT),
	.LOW_POWER_OUT(LOW_POWER_OUT), .STAGE_COUNT_OUT(STAGE_COUNT_OUT),
	.DECIMATION_OUT(DECIMATION_OUT), .EXCITE_EN_OUT(EXCITE_EN_OUT),
	.BIAS_BOOST_OUT(BIAS_BOOST_OUT)
);
`default_nettype wire

// file: tb/testbench.sv
// Purpose: Self-checking bench of the control register block
// Assumes: Short timer parameters stand in for the long intervals
// Notes: Host traffic goes through the partner model
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int FP = 20;
	localparam int LP = 10;
	localparam logic [18:0] DFLT = {2'b01, 4'h0, 4'h1, 9'h100};
	logic clk;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [9:0] addr;
	logic [7:0] wb, rb;
	logic wv, rq, fe, rv, start, done, shut, lowp, exc, irqh;
	logic res_v = 1'b0;
	logic [3:0] res_s = 4'h0;
	logic [15:0] res_d = 16'h0;
	logic [3:0] stc;
	logic [8:0] dec;
	logic [1:0] bias;
	logic [18:0] outs, x;
	logic [15:0] v, w;
	logic hit;
	logic [9:0] ta [4] = '{10'h07f, 10'h001, 10'h0ec, 10'h080};
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	assign outs = {irqh, exc, bias, shut, lowp, stc, dec};
	cdc_power_control_regs #(.FP_PERIOD_CYC(FP), .LP_UNIT_CYC(LP)) u_cdc_power_control_regs (
		.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .ADDR_IN(addr),
		.WR_BYTE_VALID_IN(wv), .WR_BYTE_IN(wb), .RD_BYTE_REQ_IN(rq), .FRAME_END_IN(fe),
		.RD_BYTE_VALID_OUT(rv), .RD_BYTE_OUT(rb), .RESULT_VALID_IN(res_v),
		.RESULT_STAGE_IN(res_s), .RESULT_DATA_IN(res_d), .CONV_START_OUT(start),
		.SEQ_DONE_OUT(done), .SHUTDOWN_OUT(shut), .LOW_POWER_OUT(lowp),
		.STAGE_COUNT_OUT(stc), .DECIMATION_OUT(dec), .EXCITE_EN_OUT(exc),
		.BIAS_BOOST_OUT(bias), .IRQ_ACTIVE_HIGH_OUT(irqh));
	cdc_host_model u_cdc_host_model (.clk_in(clk), .rd_valid_in(rv), .rd_byte_in(rb),
		.addr_out(addr), .wr_valid_out(wv), .wr_byte_out(wb), .rd_req_out(rq),
		.frame_end_out(fe));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [18:0] got, input logic [18:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	// Last gap measured: earlier ones may straddle a mode change
	task automatic per(input int exp, input int reps = 3);
		int n;
		for (int r = 0; r < reps; r++) begin
			n = 0;
			do begin
				@(posedge clk);
				#1;
				n++;
			end while (start !== 1'b1 && n < 200);
		end
		chk(n[18:0], exp[18:0]);
	endtask
	task automatic res(input logic [3:0] s, input logic exp);
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		#1;
		res_v = 1'b1;
		res_s = s;
		res_d = {12'hc00, s};
		@(posedge clk);
		#1;
		res_v = 1'b0;
		res_s = ~s;
		res_d = ~res_d;
		repeat (3) begin
			seen |= done;
			@(posedge clk);
			#1;
		end
		chk(seen, exp);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		u_cdc_host_model.rd(10'h000, v);
		chk(v, 16'h0);
		chk(outs, DFLT);
		for (int i = 0; i < 4; i++) begin
			w = {i[1:0], 1'b1, i[0], i[1], 1'b0, i[1:0], i[1:0], i[1:0], i[1:0], i[1:0]};
			u_cdc_host_model.wr(10'h000, w);
			u_cdc_host_model.rd(10'h000, v);
			chk(v, w & 16'hdfff);
			x = {i[1], ~i[0], w[15:14], i[0], i == 2, i == 3 ? 4'hc : w[7:4] + 4'h1, 9'h0};
			x[8:0] = i == 3 ? 9'h040 : 9'h100 >> i;
			chk(outs, x);
			per(i == 0 ? FP : i == 2 ? 3 * LP : 200);
		end
		for (int j = 0; j < 4; j++) begin
			u_cdc_host_model.wr(10'h000, {12'h000, j[1:0], 2'b10});
			per((j + 1) * LP);
		end
		u_cdc_host_model.wr(10'h000, 16'hffff);
		u_cdc_host_model.rd(10'h000, v);
		chk(v, 16'h0);
		chk(outs, DFLT);
		per(FP);
		// Enable low: timer and pulses hold still
		@(posedge clk);
		#1;
		ce = 1'b0;
		hit = 1'b0;
		repeat (2 * FP) begin
			@(posedge clk);
			#1;
			hit |= start;
		end
		ce = 1'b1;
		chk(hit, 1'b0);
		per(FP - 1, 1);
		u_cdc_host_model.wr(10'h000, 16'h0020);
		u_cdc_host_model.wr(10'h080, 16'ha5c3);
		for (int i = 0; i < 4; i++) u_cdc_host_model.wr(ta[i], 16'h11ff, i < 3);
		for (int s = 0; s < 3; s++) res(s[3:0], s == 2);
		u_cdc_host_model.wr(10'h0e2, 16'hffff);
		for (int i = 0; i < 4; i++) begin
			u_cdc_host_model.rd(ta[i], v);
			chk(v, ta[i] == 10'h080 ? 16'ha5c3 : 16'h0);
		end
		u_cdc_host_model.rd(10'h0e2, v);
		chk(v, 16'hc002);
		summarize();
	end
endmodule // testbench
`default_nettype wire
